// file: logic/bau_arith_unit.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bau_defs.svh"

// Contract
// - Condition false leaves results and flags
// - Add16 sums operands and carry
// - 16-bit signed overflow and underflow flags
// - Zero flag follows every result, quotient only for divide
// - Sub16 borrow sets carry, keeps complement
// - Sub carry means first below second+carry
// - Unsigned multiply gives two result words
// - Divide gives quotient, remainder; zero faults
// - Missing indirect operand raises fault flag
// - Add32 on word pairs with carry
// - 32-bit signed overflow and underflow flags
// - Sub32 borrow sets carry, keeps complement
// - Signed 16-bit multiply, two words
// - Signed 16 zero means whole product
// - Signed 32-bit multiply, four words
// - Signed 32 zero means all words
module bau_arith_unit
    import bau_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    function automatic logic in_bank(input logic [7:0] a,
                                     input logic [7:0] base);
        in_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= `BAU_OFF_LAST);
    endfunction

    // sign analysis, returns overflow then underflow
    function automatic logic [1:0] sign_chk(input logic sa,
                                            input logic sb,
                                            input logic sr,
                                            input logic sub);
        logic eb;
        eb = sb ^ sub;
        sign_chk = {~sa & ~eb & sr, sa & eb & ~sr};
    endfunction

    bau_word_t          opnd [4];
    bau_word_t          res_w [4];
    logic               carry_flag;
    logic               zero_flag;
    logic               overflow_flag;
    logic               underflow_flag;
    logic               fault_flag;
    logic [3:0]         irq_stat;
    logic [3:0]         irq_mask;
    logic [3:0]         evt;
    logic [3:0]         stat_clr;
    bau_state_e         state;
    logic [15:0]        div_rem;
    logic [15:0]        div_quo;
    logic [15:0]        div_dvs;
    logic [15:0]        div_dd;
    logic [4:0]         div_cnt;
    logic               acc_wr;
    logic               go;
    logic               ctrl_noexec;
    logic               div_done;
    bau_op_e            op_sel;
    logic               miss;
    logic [16:0]        sum16;
    logic [16:0]        dif16;
    logic [32:0]        sum32;
    logic [32:0]        dif32;
    logic [16:0]        div_shift;
    logic [16:0]        div_trial;
    logic [31:0]        mul16u;
    logic signed [31:0] smul16;
    logic signed [63:0] smul32;
    logic [1:0]         sf16a;
    logic [1:0]         sf16s;
    logic [1:0]         sf32a;
    logic [1:0]         sf32s;
    logic [31:0]        rd_val;

    assign acc_wr = psel & penable & pready & pwrite;
    assign op_sel = bau_op_e'(pwdata[`BAU_CTRL_OP_MSB:0]);
    assign miss   = pwdata[`BAU_CTRL_MISS];

    // only a set condition starts work
    assign go = acc_wr & reg_hit(paddr, `BAU_OFF_CTRL)
              & pwdata[`BAU_CTRL_EXEC] & (state == ST_IDLE);
    assign ctrl_noexec = acc_wr & reg_hit(paddr, `BAU_OFF_CTRL)
                       & ~pwdata[`BAU_CTRL_EXEC];
    assign div_done = (state == ST_DIVIDE)
                    && (div_cnt == `BAU_DIV_STEPS);
    assign stat_clr = (acc_wr & reg_hit(paddr, `BAU_OFF_ISTAT))
                    ? pwdata[3:0] : 4'h0;

    assign sum16 = {1'b0, opnd[0]} + {1'b0, opnd[2]}
                 + {16'h0, carry_flag};
    // top bit is the borrow out
    assign dif16 = {1'b0, opnd[0]} - {1'b0, opnd[2]}
                 - {16'h0, carry_flag};
    // word pairs, high word at odd index
    assign sum32 = {1'b0, opnd[1], opnd[0]} + {1'b0, opnd[3], opnd[2]}
                 + {32'h0, carry_flag};
    assign dif32 = {1'b0, opnd[1], opnd[0]} - {1'b0, opnd[3], opnd[2]}
                 - {32'h0, carry_flag};
    assign mul16u = {16'h0, opnd[0]} * {16'h0, opnd[2]};
    assign smul16 = $signed(opnd[0]) * $signed(opnd[2]);
    assign smul32 = $signed({opnd[1], opnd[0]})
                  * $signed({opnd[3], opnd[2]});
    assign sf16a = sign_chk(opnd[0][15], opnd[2][15], sum16[15], 1'b0);
    assign sf16s = sign_chk(opnd[0][15], opnd[2][15], dif16[15], 1'b1);
    assign sf32a = sign_chk(opnd[1][15], opnd[3][15], sum32[31], 1'b0);
    assign sf32s = sign_chk(opnd[1][15], opnd[3][15], dif32[31], 1'b1);

    assign div_shift = {div_rem, div_quo[15]};
    assign div_trial = div_shift - {1'b0, div_dvs};

    // APB slave: one wait-free access phase, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok(paddr);
            if (psel & ~penable & ~pwrite)
                prdata <= rd_val;
        end
    end

    always_comb
    begin
        rd_val = 32'h0;
        if (in_bank(paddr, `BAU_OFF_OPND))
            rd_val[15:0] = opnd[paddr[3:2]];
        else if (in_bank(paddr, `BAU_OFF_RES))
            rd_val[15:0] = res_w[paddr[3:2]];
        else if (reg_hit(paddr, `BAU_OFF_FLAGS))
        begin
            rd_val[`BAU_FLG_CARRY] = carry_flag;
            rd_val[`BAU_FLG_ZERO]  = zero_flag;
            rd_val[`BAU_FLG_OVF]   = overflow_flag;
            rd_val[`BAU_FLG_UNF]   = underflow_flag;
            rd_val[`BAU_FLG_FAULT] = fault_flag;
            rd_val[`BAU_FLG_BUSY]  = (state == ST_DIVIDE);
        end
        else if (reg_hit(paddr, `BAU_OFF_ISTAT))
            rd_val[3:0] = irq_stat;
        else if (reg_hit(paddr, `BAU_OFF_IMASK))
            rd_val[3:0] = irq_mask;
    end

    // Operand words, written by software at any time
    for (genvar i = 0; i < 4; i++)
    begin : g_opnd
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                opnd[i] <= `BAU_RST_WORD;
            else if (acc_wr && in_bank(paddr, `BAU_OFF_OPND)
                     && paddr[3:2] == 2'(i))
                opnd[i] <= pwdata[15:0];
        end
    end

    // Result words and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < 4; k++)
                res_w[k] <= `BAU_RST_WORD;
            carry_flag     <= 1'b0;
            zero_flag      <= 1'b0;
            overflow_flag  <= 1'b0;
            underflow_flag <= 1'b0;
            fault_flag     <= 1'b0;
            evt            <= 4'h0;
        end
        else
        begin
            evt <= 4'h0;
            if (acc_wr & reg_hit(paddr, `BAU_OFF_FLAGS))
                carry_flag <= pwdata[`BAU_FLG_CARRY];
            // absent operand faults, nothing else moves
            if (go & miss)
            begin
                fault_flag          <= 1'b1;
                evt[`BAU_EV_DONE]  <= 1'b1;
                evt[`BAU_EV_FAULT] <= 1'b1;
            end
            else if (go)
            begin
                fault_flag <= 1'b0;
                evt[`BAU_EV_DONE] <= ~(op_sel == div16u_op
                                       && opnd[2] != 16'h0);
                unique case (op_sel)
                    add16_op:
                    begin
                        res_w[0]          <= sum16[15:0];
                        carry_flag        <= sum16[16];
                        zero_flag         <= (sum16[15:0] == 16'h0);
                        overflow_flag     <= sf16a[1];
                        underflow_flag    <= sf16a[0];
                        evt[`BAU_EV_OVF] <= sf16a[1];
                        evt[`BAU_EV_UNF] <= sf16a[0];
                    end
                    sub16_op:
                    begin
                        res_w[0]          <= dif16[15:0];
                        carry_flag        <= dif16[16];
                        zero_flag         <= (dif16[15:0] == 16'h0);
                        overflow_flag     <= sf16s[1];
                        underflow_flag    <= sf16s[0];
                        evt[`BAU_EV_OVF] <= sf16s[1];
                        evt[`BAU_EV_UNF] <= sf16s[0];
                    end
                    mul16u_op:
                    begin
                        res_w[0]  <= mul16u[15:0];
                        res_w[1]  <= mul16u[31:16];
                        zero_flag <= (mul16u == 32'h0);
                    end
                    // zero divisor faults, else divider runs
                    div16u_op:
                    begin
                        if (opnd[2] == 16'h0)
                        begin
                            fault_flag          <= 1'b1;
                            evt[`BAU_EV_FAULT] <= 1'b1;
                        end
                    end
                    add32_op:
                    begin
                        res_w[0]          <= sum32[15:0];
                        res_w[1]          <= sum32[31:16];
                        carry_flag        <= sum32[32];
                        zero_flag         <= (sum32[31:0] == 32'h0);
                        overflow_flag     <= sf32a[1];
                        underflow_flag    <= sf32a[0];
                        evt[`BAU_EV_OVF] <= sf32a[1];
                        evt[`BAU_EV_UNF] <= sf32a[0];
                    end
                    sub32_op:
                    begin
                        res_w[0]          <= dif32[15:0];
                        res_w[1]          <= dif32[31:16];
                        carry_flag        <= dif32[32];
                        zero_flag         <= (dif32[31:0] == 32'h0);
                        overflow_flag     <= sf32s[1];
                        underflow_flag    <= sf32s[0];
                        evt[`BAU_EV_OVF] <= sf32s[1];
                        evt[`BAU_EV_UNF] <= sf32s[0];
                    end
                    smul16_op:
                    begin
                        res_w[0]  <= smul16[15:0];
                        res_w[1]  <= smul16[31:16];
                        zero_flag <= (smul16 == 32'sh0);
                    end
                    smul32_op:
                    begin
                        res_w[0]  <= smul32[15:0];
                        res_w[1]  <= smul32[31:16];
                        res_w[2]  <= smul32[47:32];
                        res_w[3]  <= smul32[63:48];
                        zero_flag <= (smul32 == 64'sh0);
                    end
                endcase
            end
            else if (div_done)
            begin
                res_w[0]          <= div_quo;
                res_w[1]          <= div_rem;
                zero_flag         <= (div_quo == 16'h0);
                evt[`BAU_EV_DONE] <= 1'b1;
            end
        end
    end

    // Restoring divider, one quotient bit per cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= ST_IDLE;
            div_rem <= 16'h0;
            div_quo <= 16'h0;
            div_dvs <= 16'h0;
            div_dd  <= 16'h0;
            div_cnt <= 5'h0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (go && !miss && op_sel == div16u_op
                        && opnd[2] != 16'h0)
                    begin
                        state   <= ST_DIVIDE;
                        div_rem <= 16'h0;
                        div_quo <= opnd[0];
                        div_dvs <= opnd[2];
                        div_dd  <= opnd[0];
                        div_cnt <= 5'h0;
                    end
                end
                ST_DIVIDE:
                begin
                    if (div_done)
                        state <= ST_IDLE;
                    else
                    begin
                        div_cnt <= div_cnt + 5'd1;
                        if (!div_trial[16])
                        begin
                            div_rem <= div_trial[15:0];
                            div_quo <= {div_quo[14:0], 1'b1};
                        end
                        else
                        begin
                            div_rem <= div_shift[15:0];
                            div_quo <= {div_quo[14:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat <= 4'h0;
            irq_mask <= `BAU_RST_MASK;
            irq      <= 1'b0;
        end
        else
        begin
            if (acc_wr & reg_hit(paddr, `BAU_OFF_IMASK))
                irq_mask <= pwdata[`BAU_EV_W-1:0];
            irq_stat <= (irq_stat & ~stat_clr) | evt;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // Reference values for the checks below
    logic signed [17:0] ex16a;
    logic signed [33:0] ex32s;
    logic               lt16;
    logic               lt32;
    logic               irq_want;

    assign ex16a = $signed({opnd[0][15], opnd[0]})
                 + $signed({opnd[2][15], opnd[2]})
                 + $signed({17'h0, carry_flag});
    assign ex32s = $signed({opnd[1][15], opnd[1], opnd[0]})
                 - $signed({opnd[3][15], opnd[3], opnd[2]})
                 - $signed({33'h0, carry_flag});
    assign lt16 = {1'b0, opnd[0]} < ({1'b0, opnd[2]}
                                     + {16'h0, carry_flag});
    assign lt32 = {1'b0, opnd[1], opnd[0]}
                < ({1'b0, opnd[3], opnd[2]} + {32'h0, carry_flag});
    assign irq_want = |(irq_stat & irq_mask);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_noexec_hold: assert property (
        ctrl_noexec && state == ST_IDLE
        |=> $stable(res_w[0]) && $stable(res_w[1])
            && $stable(zero_flag) && $stable(fault_flag)
            && $stable(overflow_flag) && $stable(carry_flag))
        else $error("state changed without execution condition");

    a_add16_sum: assert property (
        go && !miss && op_sel == add16_op
        |=> {carry_flag, res_w[0]}
            == $past(opnd[0]) + $past(opnd[2]) + $past(carry_flag))
        else $error("add16 sum or carry wrong");

    a_add16_range: assert property (
        go && !miss && op_sel == add16_op
        |=> overflow_flag == ($past(ex16a) > 18'sd32767)
            && underflow_flag == ($past(ex16a) < -18'sd32768))
        else $error("add16 signed range flags wrong");

    a_sub16_borrow: assert property (
        go && !miss && op_sel == sub16_op
        |=> carry_flag == $past(lt16)
            && res_w[0] == $past(opnd[0]) - $past(opnd[2])
                           - $past(carry_flag))
        else $error("sub16 borrow or result wrong");

    a_word_zero: assert property (
        go && !miss && op_sel inside {add16_op, sub16_op}
        |=> zero_flag == (res_w[0] == 16'h0))
        else $error("zero flag disagrees with result");

    a_mul16_halves: assert property (
        go && !miss && op_sel == mul16u_op
        |=> {res_w[1], res_w[0]} == $past(opnd[0]) * $past(opnd[2]))
        else $error("unsigned multiply halves wrong");

    a_div_latency: assert property (
        go && !miss && op_sel == div16u_op && opnd[2] != 16'h0
        |-> ##17 div_done ##1 (res_w[1] < div_dvs
            && zero_flag == (res_w[0] == 16'h0)))
        else $error("divide did not finish in time");

    a_div_identity: assert property (
        div_done
        |=> {16'h0, res_w[0]} * {16'h0, div_dvs} + {16'h0, res_w[1]}
            == {16'h0, div_dd})
        else $error("quotient and remainder inconsistent");

    a_div_zero: assert property (
        go && !miss && op_sel == div16u_op && opnd[2] == 16'h0
        |=> fault_flag && $stable(res_w[0]) && $stable(res_w[1])
            && state == ST_IDLE)
        else $error("zero divisor not faulted");

    a_miss_fault: assert property (
        go && miss
        |=> fault_flag && $stable(res_w[0]) && $stable(carry_flag))
        else $error("missing operand not faulted");

    a_add32_sum: assert property (
        go && !miss && op_sel == add32_op
        |=> {carry_flag, res_w[1], res_w[0]}
            == {$past(opnd[1]), $past(opnd[0])}
             + {$past(opnd[3]), $past(opnd[2])} + $past(carry_flag))
        else $error("add32 sum or carry wrong");

    a_sub32_flags: assert property (
        go && !miss && op_sel == sub32_op
        |=> carry_flag == $past(lt32)
            && overflow_flag == ($past(ex32s) > 34'sd2147483647)
            && underflow_flag == ($past(ex32s) < -34'sd2147483648))
        else $error("sub32 flags wrong");

    a_smul16_prod: assert property (
        go && !miss && op_sel == smul16_op
        |=> $signed({res_w[1], res_w[0]})
            == $signed($past(opnd[0])) * $signed($past(opnd[2]))
            && zero_flag == ({res_w[1], res_w[0]} == 32'h0))
        else $error("signed 16-bit product wrong");

    a_smul32_prod: assert property (
        go && !miss && op_sel == smul32_op
        |=> $signed({res_w[3], res_w[2], res_w[1], res_w[0]})
            == $signed({$past(opnd[1]), $past(opnd[0])})
             * $signed({$past(opnd[3]), $past(opnd[2])})
            && zero_flag == ({res_w[3], res_w[2], res_w[1],
                              res_w[0]} == 64'h0))
        else $error("signed 32-bit product wrong");

    a_irq_level: assert property (
        irq_want |=> irq)
        else $error("interrupt missing");

    a_stat_sticky: assert property (
        evt != 4'h0 |=> (irq_stat & $past(evt)) == $past(evt))
        else $error("event lost against clear");

    c_add16_carry: cover property (
        go && !miss && op_sel == add16_op && sum16[16]);
    c_div_done: cover property (div_done);
    c_smul32_zero: cover property (
        go && !miss && op_sel == smul32_op && smul32 == 64'sh0);
    c_irq_raised: cover property (irq);

endmodule

// file: logic/bau_defs.svh
`ifndef BAU_DEFS_SVH
`define BAU_DEFS_SVH

// Register byte offsets on the APB slave
`define BAU_OFF_OPND   8'h00
`define BAU_OFF_CTRL   8'h10
`define BAU_OFF_FLAGS  8'h14
`define BAU_OFF_ISTAT  8'h18
`define BAU_OFF_IMASK  8'h1c
`define BAU_OFF_RES    8'h20
`define BAU_OFF_LAST   8'h2c

// Control register fields
`define BAU_CTRL_OP_MSB 2
`define BAU_CTRL_EXEC   3
`define BAU_CTRL_MISS   4

// Flag register fields
`define BAU_FLG_CARRY  0
`define BAU_FLG_ZERO   1
`define BAU_FLG_OVF    2
`define BAU_FLG_UNF    3
`define BAU_FLG_FAULT  4
`define BAU_FLG_BUSY   5

// Interrupt status and mask fields
`define BAU_EV_DONE    0
`define BAU_EV_FAULT   1
`define BAU_EV_OVF     2
`define BAU_EV_UNF     3
`define BAU_EV_W       4

// Reset values and timing
`define BAU_RST_WORD   16'h0000
`define BAU_RST_MASK   4'h0
`define BAU_DIV_STEPS  5'd16

`endif

// file: logic/bau_pkg.sv
package bau_pkg;

    typedef enum logic [2:0] {
        add16_op   = 3'h0,
        sub16_op   = 3'h1,
        mul16u_op  = 3'h2,
        div16u_op  = 3'h3,
        add32_op   = 3'h4,
        sub32_op   = 3'h5,
        smul16_op  = 3'h6,
        smul32_op  = 3'h7
    } bau_op_e;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_DIVIDE = 1'b1
    } bau_state_e;

    typedef logic [15:0] bau_word_t;

endpackage

// file: tb/bau_seq_model.sv
`timescale 1ns/1ps
module bau_seq_model
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rd_data;
    logic        rd_err;

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    // Setup, then access held until ready; data inverted once released
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~v;
    endtask
endmodule

// file: tb/binary_arith_unit_tb_top.sv
`timescale 1ns/1ps
module binary_arith_unit_tb_top
    import bau_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] d;
    logic [15:0] er [4];
    logic        ecy, ez, eov, eun, ef;
    int          err_count = 0;
    int          compares = 0;

    bau_arith_unit bau_arith_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    bau_seq_model bau_seq_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic test_done;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bau_seq_model_i.xfer(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a);
        bau_seq_model_i.xfer(1'b0, a, 32'h0);
        d = bau_seq_model_i.rd_data;
    endtask

    // Load operands and carry, fire, then compare all words and flags
    task automatic run(input bau_op_e op, input logic [31:0] a, b,
                       input logic [2:0] f);
        longint      ua, ub, sa, sb, u, s, mx;
        logic [63:0] p;
        logic [63:0] w;
        int          nw;
        w = {b, a};
        for (int i = 0; i < 4; i++)
            wr(8'(4 * i), {16'h0, w[16*i+:16]});
        wr(8'h14, {31'h0, f[0]});
        wr(8'h10, {27'h0, f[2:1], op});
        mx = op < add32_op || op == smul16_op ? 64'hffff : 64'hffffffff;
        ua = a & mx;
        ub = b & mx;
        sa = ua > mx / 2 ? ua - mx - 1 : ua;
        sb = ub > mx / 2 ? ub - mx - 1 : ub;
        ecy = f[0];
        nw = op == smul32_op ? 4 : op < mul16u_op ? 1 : 2;
        if (f[1] && (f[2] || op == div16u_op && ub == 0))
            ef = 1'b1;
        else if (f[1])
        begin
            ef = 1'b0;
            u = op[0] ? ua - ub - f[0] : ua + ub + f[0];
            s = op[0] ? sa - sb - f[0] : sa + sb + f[0];
            case (op)
                mul16u_op: p = ua * ub;
                div16u_op: p = (ua % ub) << 16 | ua / ub;
                smul16_op, smul32_op: p = sa * sb;
                default:
                begin
                    p = u & mx;
                    ecy = op[0] ? ua < ub + f[0] : u > mx;
                    eov = s > mx / 2;
                    eun = s < -mx / 2 - 1;
                end
            endcase
            for (int i = 0; i < nw; i++)
                er[i] = p[16*i+:16];
            ez = op == div16u_op ? p[15:0] == 0 :
                 (p & ~(64'hffffffffffffffff << 16 * nw)) == 0;
        end
        rd(8'h14);
        for (int k = 0; k < 30 && d[5] !== 1'b0; k++)
            rd(8'h14);
        for (int i = 0; i < 4; i++)
        begin
            rd(8'(32 + 4 * i));
            chk("result word", {16'h0, er[i]}, d);
        end
        rd(8'h14);
        chk("flags", {27'h0, ef, eun, eov, ez, ecy}, d);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        #1_000_000;
        err_count++;
        test_done;
    end

    initial
    begin
        presetn = 1'b0;
        er = '{default: 16'h0};
        {ecy, ez, eov, eun, ef} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h14);
        chk("flags after reset", 32'h0, d);
        rd(8'h30);
        chk("unmapped error", 32'h1, {31'h0, bau_seq_model_i.rd_err});
        chk("unmapped data", 32'h0, d);
        wr(8'h1c, 32'h1);
        run(add16_op, 32'ha6e2, 32'h80c5, 3'h2);
        run(add16_op, 32'h7fff, 32'h0, 3'h3);
        run(sub16_op, 32'h8000, 32'h0, 3'h3);
        run(sub16_op, 32'hf8c5, 32'h7a03, 3'h3);
        run(sub16_op, 32'h2, 32'h2, 3'h3);
        run(sub16_op, 32'h3, 32'h2, 3'h3);
        run(mul16u_op, 32'hffff, 32'hffff, 3'h2);
        run(div16u_op, 32'h7, 32'h2, 3'h2);
        run(div16u_op, 32'h7, 32'h0, 3'h2);
        run(add32_op, 32'hffffffff, 32'h0, 3'h3);
        run(add32_op, 32'h7fffffff, 32'h1, 3'h2);
        run(sub32_op, 32'h1, 32'h2, 3'h2);
        run(sub32_op, 32'h80000000, 32'h1, 3'h2);
        run(smul16_op, 32'hffff, 32'h1, 3'h3);
        run(smul16_op, 32'h8000, 32'h0, 3'h2);
        run(smul32_op, 32'hffffffff, 32'h2, 3'h2);
        run(smul32_op, 32'h10000, 32'h0, 3'h2);
        run(add16_op, 32'h1, 32'h1, 3'h0);
        run(add16_op, 32'h1, 32'h1, 3'h6);
        chk("irq", 32'h1, {31'h0, irq});
        rd(8'h18);
        chk("irq status", 32'hf, d);
        wr(8'h18, 32'hf);
        rd(8'h18);
        chk("irq cleared", 32'h0, d);
        chk("irq low", 32'h0, {31'h0, irq});
        wr(8'h1c, 32'h0);
        run(add16_op, 32'h1, 32'h1, 3'h2);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h1c, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        test_done;
    end
endmodule
